// >>> logic/bba_pkg.sv
// Constants, types and helpers for the binary and BCD adder unit
// Functional notes
// - Execution condition false: no addition, results and flags stay unchanged.
// - Single binary add stores 16-bit sum; carry when above FFFF.
// - Double binary add uses low word first; carry when above FFFF FFFF.
// - Single binary add with carry adds carry flag as carry-in.
// - Double binary add with carry adds carry flag into 32-bit sum.
// - Zero flag set when stored result word or words are all zero.
// - Positive overflow when both operands positive and result sign negative.
// - Negative overflow when both operands negative and result sign positive.
// - Sign flag follows bit 15 of result, upper word for double forms.
// - Binary operands are two's complement; 8000 to FFFF are negative.
// - Single BCD add with digit correction; carry when above 9999.
// - Double BCD add, low digits first; carry when above 9999 9999.
// - Single BCD add with carry uses carry flag as decimal carry-in.
// - Double BCD add with carry uses carry flag as carry-in.
// - Any non-decimal nibble in BCD operands sets fault, addition skipped.
// - Invalid indirect pointer also sets fault flag.
// - Unsigned binary range is 0000 to FFFF; carry marks overflow.
package bba_pkg;

   localparam int APB_ADDR_W = 12;
   localparam int WORD_W = 16;
   localparam int SIGN_BIT = 15;

   // Register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_OPA_LO = 12'h004;
   localparam logic [11:0] OFF_OPA_HI = 12'h008;
   localparam logic [11:0] OFF_OPB_LO = 12'h00C;
   localparam logic [11:0] OFF_OPB_HI = 12'h010;
   localparam logic [11:0] OFF_RES_LO = 12'h014;
   localparam logic [11:0] OFF_RES_HI = 12'h018;
   localparam logic [11:0] OFF_FLAGS = 12'h01C;
   localparam logic [11:0] OFF_INT_STATUS = 12'h020;
   localparam logic [11:0] OFF_INT_MASK = 12'h024;

   // Control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_COND_BIT = 3;
   localparam int CTRL_PFAULT_BIT = 4;
   localparam int CTRL_GO_BIT = 8;
   localparam int CTRL_BUSY_BIT = 9;

   // Flag register fields
   localparam int FLG_W = 6;
   localparam int FLG_CARRY = 0;
   localparam int FLG_ZERO = 1;
   localparam int FLG_POVF = 2;
   localparam int FLG_NOVF = 3;
   localparam int FLG_SIGN = 4;
   localparam int FLG_FAULT = 5;

   // Interrupt fields
   localparam int INT_W = 3;
   localparam int INT_DONE = 0;
   localparam int INT_FAULT = 1;
   localparam int INT_OVF = 2;

   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [5:0] RST_FLAGS = 6'h00;
   localparam logic [2:0] RST_INT = 3'h0;
   localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

   // Decimal digit limits
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [4:0] BCD_ADJUST = 5'h06;

   // Bit 0 carry-in, bit 1 double length, bit 2 decimal
   typedef enum logic [2:0] {
      bin_add_single = 3'b000,
      bin_add_single_cin = 3'b001,
      bin_add_double = 3'b010,
      bin_add_double_cin = 3'b011,
      dec_add_single = 3'b100,
      dec_add_single_cin = 3'b101,
      dec_add_double = 3'b110,
      dec_add_double_cin = 3'b111
   } bba_op_e;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_low = 2'b01,
      st_high = 2'b11,
      st_commit = 2'b10
   } bba_state_e;

   typedef struct packed {
      logic fault_flag;
      logic sign_flag;
      logic negative_overflow_flag;
      logic positive_overflow_flag;
      logic zero_flag;
      logic carry_flag;
   } bba_flags_s;

   typedef struct packed {
      logic [15:0] sum;
      logic cout;
      logic bad;
   } bba_word_sum_s;

   function automatic logic digit_ok(input logic [3:0] nib);
      digit_ok = (nib <= BCD_DIGIT_MAX);
   endfunction : digit_ok

endpackage : bba_pkg

// >>> logic/bba_word_adder.sv
// One 16-bit word of binary or packed BCD addition
`timescale 1ns/1ps
`default_nettype none
module bba_word_adder (
   input wire logic [15:0] a,
   input wire logic [15:0] b,
   input wire logic cin,
   input wire logic dec_mode,
   output bba_pkg::bba_word_sum_s res
);

   always_comb begin
      logic [16:0] bin;
      logic [4:0] raw;
      logic c;
      logic bad;
      logic [15:0] dsum;
      bin = 17'h00000;
      raw = 5'h00;
      c = cin;
      bad = 1'b0;
      dsum = 16'h0000;
      bin = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
      for (int i = 0; i < 4; i++) begin
         if (!bba_pkg::digit_ok(a[4*i +: 4]) || !bba_pkg::digit_ok(b[4*i +: 4])) begin
            bad = 1'b1;
         end
         raw = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
         if (raw > {1'b0, bba_pkg::BCD_DIGIT_MAX}) begin
            raw = raw + bba_pkg::BCD_ADJUST;
            c = 1'b1;
         end else begin
            c = 1'b0;
         end
         dsum[4*i +: 4] = raw[3:0];
      end
      if (dec_mode) begin
         res.sum = dsum;
         res.cout = c;
         res.bad = bad;
      end else begin
         res.sum = bin[15:0];
         res.cout = bin[16];
         res.bad = 1'b0;
      end
   end

endmodule : bba_word_adder
`default_nettype wire

// >>> logic/bba_adder_unit.sv
// Binary and BCD add unit with flags, APB register access and interrupt
`timescale 1ns/1ps
`default_nettype none
module bba_adder_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic busy,
   output bba_pkg::bba_flags_s flags_out
);

   // Register file state
   bba_pkg::bba_op_e ctrl_op, next_ctrl_op;
   logic ctrl_cond, next_ctrl_cond;
   logic ctrl_pfault, next_ctrl_pfault;
   logic [15:0] opa_lo, next_opa_lo;
   logic [15:0] opa_hi, next_opa_hi;
   logic [15:0] opb_lo, next_opb_lo;
   logic [15:0] opb_hi, next_opb_hi;
   logic [2:0] int_mask, next_int_mask;
   logic [31:0] rdata, next_rdata;
   logic rerr, next_rerr;

   // Execution state
   bba_pkg::bba_state_e state, next_state;
   logic [15:0] part_lo, next_part_lo;
   logic [15:0] part_hi, next_part_hi;
   logic mid_carry, next_mid_carry;
   logic top_carry, next_top_carry;
   logic bad_acc, next_bad_acc;
   logic [15:0] res_lo, next_res_lo;
   logic [15:0] res_hi, next_res_hi;
   bba_pkg::bba_flags_s flags, next_flags;
   logic [2:0] int_status, next_int_status;

   // Decode
   logic setup_ph;
   logic wr_acc;
   logic idle;
   logic go;
   logic flags_wr;
   logic [2:0] int_clr;
   logic is_double;
   logic is_dec;
   logic [15:0] add_a;
   logic [15:0] add_b;
   logic add_cin;
   bba_pkg::bba_word_sum_s add_res;

   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign idle = (state == bba_pkg::st_idle);
   assign is_double = ctrl_op[1];
   assign is_dec = ctrl_op[2];
   // go only accepted while idle
   // Refused at setup stays refused, even if idle by the access edge
   assign go = wr_acc && idle && !rerr && (paddr == bba_pkg::OFF_CTRL) && pwdata[bba_pkg::CTRL_GO_BIT];
   assign flags_wr = wr_acc && idle && !rerr && (paddr == bba_pkg::OFF_FLAGS);
   assign int_clr = (wr_acc && (paddr == bba_pkg::OFF_INT_STATUS)) ? pwdata[2:0] : 3'h0;

   // Zero wait states; read data captured in setup
   assign pready = 1'b1;
   assign prdata = rdata;
   assign pslverr = rerr;
   assign irq = |(int_status & int_mask);
   assign busy = !idle;
   assign flags_out = flags;

   // Word slice, used for the low then the high word
   bba_word_adder u_word (
      .a(add_a),
      .b(add_b),
      .cin(add_cin),
      .dec_mode(is_dec),
      .res(add_res)
   );

   always_comb begin
      if (state == bba_pkg::st_high) begin
         add_a = opa_hi;
         add_b = opb_hi;
         // low half carry into high half
         add_cin = mid_carry;
      end else begin
         add_a = opa_lo;
         add_b = opb_lo;
         add_cin = ctrl_op[0] && flags.carry_flag;
      end
   end

   // Register file and APB read path
   always_comb begin
      logic wr_ok;
      logic known;
      wr_ok = wr_acc && idle && !rerr;
      known = 1'b1;
      next_ctrl_op = ctrl_op;
      next_ctrl_cond = ctrl_cond;
      next_ctrl_pfault = ctrl_pfault;
      next_opa_lo = opa_lo;
      next_opa_hi = opa_hi;
      next_opb_lo = opb_lo;
      next_opb_hi = opb_hi;
      next_int_mask = int_mask;
      next_rdata = rdata;
      next_rerr = rerr;
      // Operands locked while busy so they cannot change mid-add
      if (wr_ok) begin
         unique case (paddr)
            bba_pkg::OFF_CTRL: begin
               next_ctrl_op = bba_pkg::bba_op_e'(pwdata[bba_pkg::CTRL_OP_LSB +: 3]);
               next_ctrl_cond = pwdata[bba_pkg::CTRL_COND_BIT];
               next_ctrl_pfault = pwdata[bba_pkg::CTRL_PFAULT_BIT];
            end
            bba_pkg::OFF_OPA_LO: next_opa_lo = pwdata[15:0];
            bba_pkg::OFF_OPA_HI: next_opa_hi = pwdata[15:0];
            bba_pkg::OFF_OPB_LO: next_opb_lo = pwdata[15:0];
            bba_pkg::OFF_OPB_HI: next_opb_hi = pwdata[15:0];
            default: begin
            end
         endcase
      end
      if (wr_acc && (paddr == bba_pkg::OFF_INT_MASK)) begin
         next_int_mask = pwdata[2:0];
      end
      if (setup_ph) begin
         next_rdata = 32'h0000_0000;
         unique case (paddr)
            bba_pkg::OFF_CTRL: begin
               next_rdata[bba_pkg::CTRL_OP_LSB +: 3] = ctrl_op;
               next_rdata[bba_pkg::CTRL_COND_BIT] = ctrl_cond;
               next_rdata[bba_pkg::CTRL_PFAULT_BIT] = ctrl_pfault;
               next_rdata[bba_pkg::CTRL_BUSY_BIT] = !idle;
            end
            bba_pkg::OFF_OPA_LO: next_rdata[15:0] = opa_lo;
            bba_pkg::OFF_OPA_HI: next_rdata[15:0] = opa_hi;
            bba_pkg::OFF_OPB_LO: next_rdata[15:0] = opb_lo;
            bba_pkg::OFF_OPB_HI: next_rdata[15:0] = opb_hi;
            bba_pkg::OFF_RES_LO: next_rdata[15:0] = res_lo;
            bba_pkg::OFF_RES_HI: next_rdata[15:0] = res_hi;
            bba_pkg::OFF_FLAGS: next_rdata[5:0] = flags;
            bba_pkg::OFF_INT_STATUS: next_rdata[2:0] = int_status;
            bba_pkg::OFF_INT_MASK: next_rdata[2:0] = int_mask;
            default: known = 1'b0;
         endcase
         // Unmapped, or a locked register written while busy
         next_rerr = !known || (pwrite && !idle && (paddr <= bba_pkg::OFF_OPB_HI
                     || paddr == bba_pkg::OFF_FLAGS));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_op <= bba_pkg::bin_add_single;
         ctrl_cond <= 1'b0;
         ctrl_pfault <= 1'b0;
         opa_lo <= bba_pkg::RST_WORD;
         opa_hi <= bba_pkg::RST_WORD;
         opb_lo <= bba_pkg::RST_WORD;
         opb_hi <= bba_pkg::RST_WORD;
         int_mask <= bba_pkg::RST_INT;
         rdata <= bba_pkg::RST_PRDATA;
         rerr <= 1'b0;
      end else begin
         ctrl_op <= next_ctrl_op;
         ctrl_cond <= next_ctrl_cond;
         ctrl_pfault <= next_ctrl_pfault;
         opa_lo <= next_opa_lo;
         opa_hi <= next_opa_hi;
         opb_lo <= next_opb_lo;
         opb_hi <= next_opb_hi;
         int_mask <= next_int_mask;
         rdata <= next_rdata;
         rerr <= next_rerr;
      end
   end

   // Sequencing, results, flags and interrupt status
   always_comb begin
      logic [2:0] ev;
      logic [15:0] top;
      logic a_neg;
      logic b_neg;
      logic go_cond;
      logic go_pf;
      ev = 3'h0;
      top = 16'h0000;
      a_neg = 1'b0;
      b_neg = 1'b0;
      go_cond = go && pwdata[bba_pkg::CTRL_COND_BIT];
      go_pf = pwdata[bba_pkg::CTRL_PFAULT_BIT];
      next_state = state;
      next_part_lo = part_lo;
      next_part_hi = part_hi;
      next_mid_carry = mid_carry;
      next_top_carry = top_carry;
      next_bad_acc = bad_acc;
      next_res_lo = res_lo;
      next_res_hi = res_hi;
      next_flags = flags;
      if (flags_wr) begin
         next_flags = bba_pkg::bba_flags_s'(pwdata[bba_pkg::FLG_W-1:0]);
      end
      unique case (state)
         bba_pkg::st_idle: begin
            if (go) begin
               ev[bba_pkg::INT_DONE] = 1'b1;
               // condition off completes with nothing changed
               if (go_cond && go_pf) begin
                  next_flags.fault_flag = 1'b1;
                  ev[bba_pkg::INT_FAULT] = 1'b1;
               end else if (go_cond) begin
                  ev[bba_pkg::INT_DONE] = 1'b0;
                  next_state = bba_pkg::st_low;
               end
            end
         end
         bba_pkg::st_low: begin
            next_part_lo = add_res.sum;
            next_mid_carry = add_res.cout;
            next_bad_acc = add_res.bad;
            next_state = is_double ? bba_pkg::st_high : bba_pkg::st_commit;
         end
         bba_pkg::st_high: begin
            next_part_hi = add_res.sum;
            next_top_carry = add_res.cout;
            next_bad_acc = bad_acc || add_res.bad;
            next_state = bba_pkg::st_commit;
         end
         bba_pkg::st_commit: begin
            next_state = bba_pkg::st_idle;
            ev[bba_pkg::INT_DONE] = 1'b1;
            if (bad_acc) begin
               // fault, results and other flags untouched
               next_flags.fault_flag = 1'b1;
               ev[bba_pkg::INT_FAULT] = 1'b1;
            end else begin
               next_res_lo = part_lo;
               if (is_double) begin
                  next_res_hi = part_hi;
               end
               top = is_double ? part_hi : part_lo;
               // sign taken from the upper word for double forms, the low word for single forms
               a_neg = is_double ? opa_hi[bba_pkg::SIGN_BIT] : opa_lo[bba_pkg::SIGN_BIT];
               b_neg = is_double ? opb_hi[bba_pkg::SIGN_BIT] : opb_lo[bba_pkg::SIGN_BIT];
               next_flags.fault_flag = 1'b0;
               next_flags.carry_flag = is_double ? top_carry : mid_carry;
               next_flags.zero_flag = (part_lo == 16'h0000) && (!is_double || part_hi == 16'h0000);
               // Decimal forms leave the signed flags alone
               if (!is_dec) begin
                  next_flags.sign_flag = top[bba_pkg::SIGN_BIT];
                  next_flags.positive_overflow_flag = !a_neg && !b_neg && top[bba_pkg::SIGN_BIT];
                  next_flags.negative_overflow_flag = a_neg && b_neg && !top[bba_pkg::SIGN_BIT];
                  ev[bba_pkg::INT_OVF] = next_flags.positive_overflow_flag
                                         || next_flags.negative_overflow_flag;
               end
            end
         end
      endcase
      // New events win over a same-cycle clear
      next_int_status = (int_status & ~int_clr) | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= bba_pkg::st_idle;
         part_lo <= bba_pkg::RST_WORD;
         part_hi <= bba_pkg::RST_WORD;
         mid_carry <= 1'b0;
         top_carry <= 1'b0;
         bad_acc <= 1'b0;
         res_lo <= bba_pkg::RST_WORD;
         res_hi <= bba_pkg::RST_WORD;
         flags <= bba_pkg::bba_flags_s'(bba_pkg::RST_FLAGS);
         int_status <= bba_pkg::RST_INT;
      end else begin
         state <= next_state;
         part_lo <= next_part_lo;
         part_hi <= next_part_hi;
         mid_carry <= next_mid_carry;
         top_carry <= next_top_carry;
         bad_acc <= next_bad_acc;
         res_lo <= next_res_lo;
         res_hi <= next_res_hi;
         flags <= next_flags;
         int_status <= next_int_status;
      end
   end

endmodule : bba_adder_unit
`default_nettype wire

// >>> test/bba_adder_unit_properties.sv
// Port checks for the adder unit
`timescale 1ns/1ps
`default_nettype none
module bba_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic busy,
   input wire bba_pkg::bba_flags_s flags_out
);
   wire logic wr = psel && penable && pwrite;
   wire logic go = wr && paddr == bba_pkg::OFF_CTRL && pwdata[bba_pkg::CTRL_GO_BIT] && !busy && !pslverr;
   wire logic cond = pwdata[bba_pkg::CTRL_COND_BIT];
   wire logic pfault = pwdata[bba_pkg::CTRL_PFAULT_BIT];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_cond_off: assert property (go && !cond |=> !busy && $stable(flags_out))
      else $error("add ran with condition off");
   chk_busy_cause: assert property ($rose(busy) |-> $past(go && cond && !pfault))
      else $error("busy rose without a start");
   chk_single_time: assert property (go && cond && !pfault && !pwdata[1] |=> busy ##1 busy ##1 !busy)
      else $error("single add timing wrong");
   chk_double_time: assert property (go && cond && !pfault && pwdata[1] |=> busy [*3] ##1 !busy)
      else $error("double add timing wrong");
   chk_ptr_fault: assert property (go && cond && pfault |=> flags_out.fault_flag && !busy && $stable(flags_out[4:0]))
      else $error("pointer fault not flagged");
   chk_flag_cause: assert property ($changed(flags_out) |-> $past(busy) || $past(wr))
      else $error("flags moved with no cause");
   chk_bcd_fault: assert property ($rose(flags_out.fault_flag) && $past(busy) |-> $stable(flags_out[4:0]))
      else $error("fault add touched other flags");
   chk_busy_lock: assert property (psel && !penable && pwrite && busy && paddr == bba_pkg::OFF_FLAGS ##1 busy |-> pslverr)
      else $error("write while busy not refused");
   chk_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase stretched");
endmodule : bba_props
bind bba_adder_unit bba_props u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .irq, .busy, .flags_out);
`default_nettype wire

// >>> test/bba_seq.sv
// Sequencer model: APB master loading operands and starting adds
`timescale 1ns/1ps
`default_nettype none
module bba_seq (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic hung = 1'h0;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'hFFF;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      hung = (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Released lines show junk, not stale data
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : bba_seq
`default_nettype wire

// >>> test/test_binary_bcd_adder_flags.sv
// Self-checking bench for the binary and BCD adder unit
`timescale 1ns/1ps
`default_nettype none
module test_binary_bcd_adder_flags;
   typedef struct packed {
      logic [2:0] op;
      logic cin;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] r;
      logic [5:0] f;
   } bba_row_s;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr, irq, busy, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   bba_pkg::bba_flags_s flags_out;
   int num_errors = 0;
   int n_checks = 0;
   // Carry preload on plain forms must be ignored
   bba_row_s rows [13] = '{
      '{3'h0, 1'h1, 32'h0000_7FFF, 32'h0000_0001, 32'h0000_8000, 6'h14},
      '{3'h0, 1'h0, 32'h0000_FFFF, 32'h0000_0001, 32'h0000_0000, 6'h03},
      '{3'h1, 1'h0, 32'h0000_8000, 32'h0000_8000, 32'h0000_0000, 6'h0B},
      '{3'h1, 1'h1, 32'h0000_FFFD, 32'h0000_0001, 32'h0000_FFFF, 6'h10},
      '{3'h2, 1'h1, 32'h0000_FFFF, 32'h0000_0001, 32'h0001_0000, 6'h00},
      '{3'h3, 1'h1, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 6'h03},
      '{3'h3, 1'h1, 32'h7FFF_FFFF, 32'h0000_0000, 32'h8000_0000, 6'h14},
      '{3'h4, 1'h1, 32'h0000_9999, 32'h0000_0001, 32'h0000_0000, 6'h03},
      '{3'h5, 1'h1, 32'h0000_1234, 32'h0000_5678, 32'h0000_6913, 6'h00},
      '{3'h6, 1'h0, 32'h1234_9999, 32'h8765_0001, 32'h0000_0000, 6'h03},
      '{3'h7, 1'h1, 32'h0000_0005, 32'h0000_0004, 32'h0000_0010, 6'h00},
      '{3'h4, 1'h0, 32'h0000_00A0, 32'h0000_0001, 32'h0000_0010, 6'h20},
      '{3'h6, 1'h0, 32'h0000_0000, 32'hF000_0000, 32'h0000_0010, 6'h20}};
   always #4 pclk = ~pclk;
   bba_seq u_seq (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   bba_adder_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .busy, .flags_out);
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   always @(posedge pclk) begin
      if (u_seq.hung) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_seq.xfer(1'h1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      u_seq.xfer(1'h0, a, 32'h0000_0000, q, e);
   endtask : rd
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (busy !== 1'h0 && n < 20);
      if (busy !== 1'h0) begin
         num_errors++;
         give_verdict();
      end
   endtask : wait_idle
   task automatic sense(input logic [31:0] f, input logic bz, input logic iq);
      @(negedge pclk);
      chk("flags", f, {26'h0, flags_out});
      chk("busy", {31'h0, bz}, {31'h0, busy});
      chk("irq", {31'h0, iq}, {31'h0, irq});
   endtask : sense
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[i]) begin
         wr(bba_pkg::OFF_FLAGS, {31'h0, rows[i].cin});
         wr(bba_pkg::OFF_OPA_LO, {16'h0, rows[i].a[15:0]});
         wr(bba_pkg::OFF_OPA_HI, {16'h0, rows[i].a[31:16]});
         wr(bba_pkg::OFF_OPB_LO, {16'h0, rows[i].b[15:0]});
         wr(bba_pkg::OFF_OPB_HI, {16'h0, rows[i].b[31:16]});
         wr(bba_pkg::OFF_CTRL, 32'h0000_0108 | {29'h0, rows[i].op});
         wait_idle();
         chk("flags", {26'h0, rows[i].f}, {26'h0, flags_out});
         rd(bba_pkg::OFF_RES_LO);
         chk("res_lo", {16'h0, rows[i].r[15:0]}, q);
         if (rows[i].op[1]) begin
            rd(bba_pkg::OFF_RES_HI);
            chk("res_hi", {16'h0, rows[i].r[31:16]}, q);
         end
      end
      // Rows raised done, overflow and fault events
      rd(bba_pkg::OFF_INT_STATUS);
      chk("int_status_rows", 32'h0000_0007, q);
      wr(bba_pkg::OFF_FLAGS, 32'h0000_0015);
      wr(bba_pkg::OFF_CTRL, 32'h0000_0100);
      sense(32'h15, 1'h0, 1'h0);
      rd(bba_pkg::OFF_RES_LO);
      chk("res_lo", 32'h0000_0010, q);
      wr(bba_pkg::OFF_INT_STATUS, 32'h0000_0007);
      wr(bba_pkg::OFF_INT_MASK, 32'h0000_0001);
      sense(32'h15, 1'h0, 1'h0);
      wr(bba_pkg::OFF_CTRL, 32'h0000_0100);
      sense(32'h15, 1'h0, 1'h1);
      wr(bba_pkg::OFF_INT_MASK, 32'h0000_0000);
      sense(32'h15, 1'h0, 1'h0);
      wr(bba_pkg::OFF_INT_STATUS, 32'h0000_0007);
      wr(bba_pkg::OFF_FLAGS, 32'h0000_0000);
      wr(bba_pkg::OFF_CTRL, 32'h0000_0118);
      sense(32'h20, 1'h0, 1'h0);
      rd(bba_pkg::OFF_INT_STATUS);
      chk("int_status", 32'h0000_0003, q);
      wr(bba_pkg::OFF_CTRL, 32'h0000_010A);
      wr(bba_pkg::OFF_FLAGS, 32'h0000_003F);
      chk("busy_err", 32'h1, {31'h0, e});
      wait_idle();
      chk("flags", 32'h10, {26'h0, flags_out});
      rd(bba_pkg::OFF_RES_HI);
      chk("res_hi", 32'h0000_F000, q);
      rd(12'h040);
      chk("unmapped", 32'h0000_0001, {31'h0, e});
      chk("unmapped_q", 32'h0000_0000, q);
      wr(bba_pkg::OFF_RES_LO, 32'h0000_FFFF);
      rd(bba_pkg::OFF_RES_LO);
      chk("res_lo_ro", 32'h0000_0000, q);
      @(posedge pclk);
      presetn <= 1'h0;
      sense(32'h00, 1'h0, 1'h0);
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rd(bba_pkg::OFF_RES_HI);
      chk("res_hi_rst", 32'h0000_0000, q);
      give_verdict();
   end
endmodule : test_binary_bcd_adder_flags
`default_nettype wire
